// >>> flash_guard_cfg.svh
`ifndef FLASH_GUARD_CFG_SVH
`define FLASH_GUARD_CFG_SVH

// Internal RAM base and vector offsets for self-programming
`define RAM_BASE_ADDR 32'h03FF_0000
`define MI_VEC_OFFSET 32'h0000_0004
`define NMI_VEC_OFFSET 32'h0000_0000
// Flash vector addresses used in normal operation
`define FLASH_NMI_VEC 32'h0000_0010
`define FLASH_MI_BASE 32'h0000_0080
// Block-number fields: blocks 0-7 vs 8-15 differ in bit 3, 128-135 vs 136-143 likewise
`define SWAP_BIT 3
`define BLK_GROUP_LO_MAX 8'h0F
`define BLK_GROUP_HI_MIN 8'h80
`define BLK_GROUP_HI_MAX 8'h8F

`endif

// >>> flash_guard_pkg.sv
package flash_guard_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PROGRAMMER
  } boot_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SELF_PROG,
    ST_BUSY
  } guard_state_t;
endpackage

// >>> block_swap_map.sv
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"

module block_swap_map #(
  parameter int BLK_W = 8
) (
  input wire logic [BLK_W-1:0] blk_logical, // Block number seen by the CPU
  input wire logic swapped, // Boot swap currently in effect
  output logic [BLK_W-1:0] blk_physical // Block number driven to the array
);
  function automatic logic in_swap_range(input logic [BLK_W-1:0] b);
    in_swap_range = (b <= BLK_W'(`BLK_GROUP_LO_MAX)) ||
                    ((b >= BLK_W'(`BLK_GROUP_HI_MIN)) && (b <= BLK_W'(`BLK_GROUP_HI_MAX)));
  endfunction

  wire logic flip = swapped && in_swap_range(blk_logical); // [R7] [R8]
  assign blk_physical = blk_logical ^ (BLK_W'(flip) << `SWAP_BIT); // [R7] [R8]
endmodule

// >>> flash_self_program_guard.sv
// Operation
// R1: Guard pin level picks mode at reset release; rewrites blocked unless pin high.
// R2: System holds guard pin low after reset for normal operation.
// R3: Software raises guard pin before rewriting and holds it throughout self-programming.
// R4: Software returns guard pin low after self-programming ends.
// R5: In self-programming, maskable interrupts vector to RAM start plus four.
// R6: In self-programming, NMI vectors to RAM start.
// R7: Boot swap exchanges flash blocks 0-7 with blocks 8-15.
// R8: Boot swap also exchanges blocks 128-135 with blocks 136-143.
// R9: Software erases 8-15, writes boot, rewrites boot flag, then swaps.
// R10: Self-programming code resides outside the flash block being modified.
// R11: No flash instruction fetch while self-programming hardware operations run.
// R12: Normal flash vectoring and fetch return when self-programming state ends.
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"

module flash_self_program_guard
  import flash_guard_pkg::*;
#(
  parameter int BLK_W = 8,
  parameter int VEC_W = 6
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic flash_write_guard_pin, // Guard pin level, high permits rewrites
  input wire logic sp_enter, // Library request: enter self-programming state
  input wire logic sp_exit, // Library request: leave self-programming state
  input wire logic hw_op_start, // Erase or write operation starts
  input wire logic hw_op_done, // Erase or write operation finished
  input wire logic rewrite_req, // Request to erase or write flash
  input wire logic swap_req, // Boot swap execution request
  input wire logic nmi_ack, // NMI accepted by the CPU
  input wire logic mi_ack, // Maskable interrupt accepted by the CPU
  input wire logic [VEC_W-1:0] mi_code, // Index of the accepted maskable interrupt
  input wire logic [BLK_W-1:0] blk_logical, // Block addressed by the CPU
  output logic prog_mode_r, // Programmer mode latched at reset release
  output logic self_prog_r, // Self-programming state active
  output logic rewrite_grant_r, // Rewrite allowed this cycle
  output logic rewrite_blocked_r, // Rewrite refused, guard pin low or not in self-programming state
  output logic fetch_inhibit_r, // Flash instruction fetch forbidden
  output logic swapped_r, // Boot swap in effect
  output logic vec_valid_r, // Vector address valid, one-cycle pulse
  output logic [31:0] vec_addr_r, // Interrupt handler vector address
  output logic [BLK_W-1:0] blk_physical_r // Physical block after swap mapping
);
  guard_state_t state_r;
  guard_state_t state_nxt;
  logic mode_done_r;
  logic [BLK_W-1:0] blk_map;

  // Mapping is combinational; the registered copy below keeps the output glitch-free
  block_swap_map #(.BLK_W(BLK_W)) u_map (
    .blk_logical(blk_logical),
    .swapped(swapped_r),
    .blk_physical(blk_map)
  );

  // Array operation in progress
  function automatic logic op_active(input guard_state_t s);
    op_active = (s == ST_BUSY);
  endfunction

  // Inside the self-programming window, busy or not
  function automatic logic sp_active(input guard_state_t s);
    sp_active = (s != ST_IDLE);
  endfunction

  wire logic in_sp;
  wire logic pin_ok;
  wire logic grant;
  wire logic refuse;
  wire logic swap_go;
  wire logic vec_load;
  wire logic sp_nxt;
  wire logic busy_nxt;
  wire logic [31:0] mi_flash;
  wire logic [31:0] nmi_sel;
  wire logic [31:0] mi_sel;
  wire logic [31:0] vec_nxt;
  boot_mode_t strap_mode;

  assign in_sp = sp_active(state_r);
  assign pin_ok = flash_write_guard_pin; // [R1]
  assign grant = in_sp && rewrite_req && pin_ok; // [R1]
  assign refuse = rewrite_req && !(in_sp && pin_ok); // [R1]
  // No swap once the array is busy; a swap_req in the same cycle as hw_op_start still toggles the mapping
  assign swap_go = in_sp && swap_req && pin_ok && !op_active(state_r); // [R1] [R7] [R8]
  assign vec_load = nmi_ack | mi_ack;
  assign sp_nxt = sp_active(state_nxt);
  assign busy_nxt = op_active(state_nxt); // [R11]
  assign strap_mode = flash_write_guard_pin ? MODE_PROGRAMMER : MODE_NORMAL; // [R1]
  // Flash-resident table: one 16-byte slot per interrupt index
  assign mi_flash = `FLASH_MI_BASE + {{(28-VEC_W){1'b0}}, mi_code, 4'h0};
  assign nmi_sel = in_sp ? (`RAM_BASE_ADDR + `NMI_VEC_OFFSET)
                         : `FLASH_NMI_VEC; // [R6] [R12]
  assign mi_sel = in_sp ? (`RAM_BASE_ADDR + `MI_VEC_OFFSET)
                        : mi_flash; // [R5] [R12]
  // NMI outranks a maskable interrupt accepted in the same cycle
  assign vec_nxt = nmi_ack ? nmi_sel : mi_sel;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (sp_enter)
          state_nxt = ST_SELF_PROG;
      end
      ST_SELF_PROG:
      begin
        if (sp_exit)
          state_nxt = ST_IDLE; // [R12]
        else if (hw_op_start && pin_ok)
          state_nxt = ST_BUSY; // [R1] [R11]
      end
      // An exit request during an operation is dropped; software repeats it after done
      ST_BUSY:
      begin
        if (hw_op_done)
          state_nxt = ST_SELF_PROG;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Self-programming state register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Mode strap sampled once, on the first clock after reset release
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mode_done_r <= 1'b0;
    else
      mode_done_r <= 1'b1;
  end

  // Latched once, so later pin moves during self-programming leave the mode alone
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prog_mode_r <= 1'b0;
    else if (!mode_done_r)
      prog_mode_r <= (strap_mode == MODE_PROGRAMMER); // [R1]
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      self_prog_r <= 1'b0;
    else
      self_prog_r <= sp_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rewrite_grant_r <= 1'b0;
    else
      rewrite_grant_r <= grant; // [R1]
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rewrite_blocked_r <= 1'b0;
    else
      rewrite_blocked_r <= refuse; // [R1]
  end

  // Inhibit only while the array works; an idle self-programming window still fetches
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      fetch_inhibit_r <= 1'b0;
    else
      fetch_inhibit_r <= busy_nxt; // [R11] [R12]
  end

  // Volatile by choice: every reset returns the native block mapping
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      swapped_r <= 1'b0;
    else if (swap_go)
      swapped_r <= ~swapped_r; // [R7] [R8]
  end

  // Strobe follows every acknowledge, in either mode
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      vec_valid_r <= 1'b0;
    else
      vec_valid_r <= vec_load;
  end

  // Address holds between acknowledges so a late reader still sees the last vector
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      vec_addr_r <= 32'h0000_0000;
    else if (vec_load)
      vec_addr_r <= vec_nxt; // [R5] [R6]
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      blk_physical_r <= '0;
    else
      blk_physical_r <= blk_map; // [R7] [R8]
  end
endmodule

// >>> guard_properties.sv
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"
module guard_check (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic flash_write_guard_pin, // Guard pin
  input wire logic rewrite_req, // Rewrite
  input wire logic hw_op_start, // Op start
  input wire logic hw_op_done, // Op done
  input wire logic sp_exit, // Exit request
  input wire logic nmi_ack, // NMI
  input wire logic mi_ack, // Maskable
  input wire logic [5:0] mi_code, // Code
  input wire logic [7:0] blk_logical, // Block in
  input wire logic self_prog_r, // State
  input wire logic rewrite_grant_r, // Grant
  input wire logic rewrite_blocked_r, // Refusal
  input wire logic fetch_inhibit_r, // Inhibit
  input wire logic swapped_r, // Swap
  input wire logic vec_valid_r, // Vector strobe
  input wire logic [31:0] vec_addr_r, // Vector
  input wire logic [7:0] blk_physical_r // Block out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_grant_needs_pin: assert property (rewrite_grant_r |->
    $past(flash_write_guard_pin) && $past(self_prog_r)) else $error("grant without pin");
  a_refuse_low_pin: assert property (rewrite_req && !flash_write_guard_pin |=>
    rewrite_blocked_r && !rewrite_grant_r) else $error("rewrite not refused");
  a_op_inhibits_fetch: assert property (hw_op_start && flash_write_guard_pin && self_prog_r
    && !hw_op_done && !sp_exit |=> fetch_inhibit_r) else $error("fetch not inhibited");
  a_swap_needs_pin: assert property ($changed(swapped_r) |->
    $past(flash_write_guard_pin) && $past(self_prog_r) && !$past(fetch_inhibit_r))
    else $error("swap without guard");
  a_nmi_ram_entry: assert property (nmi_ack && self_prog_r |=>
    vec_valid_r && vec_addr_r == `RAM_BASE_ADDR) else $error("nmi vector wrong");
  a_mi_ram_entry: assert property (mi_ack && !nmi_ack && self_prog_r |=>
    vec_addr_r == `RAM_BASE_ADDR + `MI_VEC_OFFSET) else $error("mi vector wrong");
  a_mi_flash_entry: assert property (mi_ack && !nmi_ack && !self_prog_r |=>
    vec_addr_r == `FLASH_MI_BASE + {$past(mi_code), 4'h0}) else $error("flash vector wrong");
  a_swap_group_map: assert property ($past(swapped_r, 2) && $past(swapped_r) &&
    ($past(blk_logical) & 8'h70) == 8'h00 |-> blk_physical_r == ($past(blk_logical) ^ 8'h08))
    else $error("swap map wrong");
  a_plain_block_map: assert property ($past(rst_n) && !$past(swapped_r, 2) && !$past(swapped_r)
    |-> blk_physical_r == $past(blk_logical)) else $error("plain map wrong");
  cover property (swapped_r && blk_physical_r != blk_logical);
  cover property (vec_valid_r && self_prog_r);
  cover property (rewrite_blocked_r && self_prog_r);
endmodule
bind flash_self_program_guard guard_check i_check (.*);

// >>> tb.sv
`timescale 1ns/1ps
`include "flash_guard_cfg.svh"
module tb;
  logic clk_sys = 0, rst_n = 0, flash_write_guard_pin = 0, sp_enter = 0, sp_exit = 0;
  logic hw_op_start = 0, hw_op_done = 0, rewrite_req = 0, swap_req = 0, nmi_ack = 0, mi_ack = 0;
  logic [5:0] mi_code = 0;
  logic [7:0] blk_logical = 0, blk_physical_r, b;
  logic prog_mode_r, self_prog_r, rewrite_grant_r, rewrite_blocked_r, fetch_inhibit_r, swapped_r;
  logic vec_valid_r;
  logic [31:0] vec_addr_r;
  logic [31:0] q[$];
  int error_cnt = 0, checked = 0;
  flash_self_program_guard i_dut (.*);
  always #5 clk_sys = ~clk_sys;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One-cycle pulse; returns at the falling edge where the registered answer shows
  task automatic p(ref logic s);
    s = 1;
    @(negedge clk_sys) s = 0;
  endtask
  always @(negedge clk_sys)
  begin
    if (vec_valid_r === 1'b1) chk("vec_addr_r", vec_addr_r, q.pop_front());
    if ((rewrite_grant_r | rewrite_blocked_r) === 1'b1)
      chk("rewrite", {rewrite_grant_r, rewrite_blocked_r}, q.pop_front());
  end
  initial
  begin
    #5000;
    error_cnt++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(32'hB34D));
    repeat (5) @(negedge clk_sys);
    rst_n = 1;
    @(negedge clk_sys);
    chk("prog_mode_r", prog_mode_r, 0);
    q.push_back(1);
    p(rewrite_req);
    p(sp_enter);
    chk("self_prog_r", self_prog_r, 1);
    flash_write_guard_pin = 1;
    q.push_back(2);
    p(rewrite_req);
    blk_logical = 8'h08;
    // Erase the spare boot group, write the new boot, rewrite the boot flag
    repeat (3)
    begin
      p(hw_op_start);
      chk("fetch_inhibit_r", fetch_inhibit_r, 1);
      p(hw_op_done);
      chk("fetch_inhibit_r", fetch_inhibit_r, 0);
    end
    q.push_back(`RAM_BASE_ADDR + `NMI_VEC_OFFSET);
    p(nmi_ack);
    mi_code = 6'($urandom);
    q.push_back(`RAM_BASE_ADDR + `MI_VEC_OFFSET);
    p(mi_ack);
    p(swap_req);
    chk("swapped_r", swapped_r, 1);
    repeat (4)
    begin
      b = 8'($urandom);
      blk_logical = {b[7], 3'h0, b[3:0]};
      @(negedge clk_sys) chk("blk_physical_r", blk_physical_r, blk_logical ^ 8'h08);
    end
    blk_logical = 8'h90;
    @(negedge clk_sys) chk("blk_physical_r", blk_physical_r, 8'h90);
    p(sp_exit);
    chk("self_prog_r", self_prog_r, 0);
    flash_write_guard_pin = 0;
    q.push_back(`FLASH_NMI_VEC);
    mi_ack = 1;
    p(nmi_ack);
    mi_ack = 0;
    // Guard pin left low on purpose: nothing may rewrite, start or swap
    p(sp_enter);
    q.push_back(1);
    p(rewrite_req);
    p(hw_op_start);
    chk("fetch_inhibit_r", fetch_inhibit_r, 0);
    p(swap_req);
    chk("swapped_r", swapped_r, 1);
    p(sp_exit);
    mi_code = 6'($urandom);
    q.push_back(`FLASH_MI_BASE + {mi_code, 4'h0});
    p(mi_ack);
    @(negedge clk_sys) chk("pending", q.size(), 0);
    flash_write_guard_pin = 1;
    rst_n = 0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    @(negedge clk_sys);
    chk("prog_mode_r", prog_mode_r, 1);
    chk("swapped_r", swapped_r, 0);
    flash_write_guard_pin = 0;
    blk_logical = 8'h03;
    @(negedge clk_sys) chk("blk_physical_r", blk_physical_r, 8'h03);
    wrap_up;
  end
endmodule
